/* File: hdl/flash_map_params.svh */
// Constants of the serial flash array map: commands, geometry, fills,
// parameter-space layout and frame byte positions.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FLASH_MAP_PARAMS_SVH
`define FLASH_MAP_PARAMS_SVH

// ==========================================================
// Command codes
`define CMD_READ 8'h03
`define CMD_PROG 8'h02
`define CMD_SECT_ERASE 8'h20
`define CMD_BLK_ERASE 8'hd8
`define CMD_CHIP_ERASE 8'hc7
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_STAT1 8'h05
`define CMD_STAT2 8'h35
`define CMD_WSTAT2 8'h31
`define CMD_SEC_ERASE 8'h44
`define CMD_SEC_PROG 8'h42
`define CMD_SEC_READ 8'h48
`define CMD_PARAM_READ 8'h5a

// ==========================================================
// Geometry and fills
`define ADDR_WIDTH 24
`define SECTOR_PAGES 16
`define BLOCK_PAGES 256
`define ERASED_BYTE 8'hff
`define LAST_BYTE_IN_PAGE 8'hff

// ==========================================================
// Parameter-space header bytes
`define PT_SIG_S 8'h53
`define PT_SIG_F 8'h46
`define PT_SIG_D 8'h44
`define PT_SIG_P 8'h50
`define PT_MINOR_REV 8'h06
`define PT_MAJOR_REV 8'h01
`define PT_NUM_HEADERS 8'h00

// ==========================================================
// Frame byte indices: first data bytes, last address byte, WSTAT2 frame end, saturation
`define IDX_STAT_DATA 3'd1
`define IDX_ADDR_DONE 3'd3
`define IDX_READ_DATA 3'd4
`define IDX_PARAM_DATA 3'd5
`define IDX_WSTAT2_END 3'd2
`define IDX_BYTE_SAT 3'd7
`endif

/* File: hdl/flash_map_pkg.sv */
// Types shared by the serial flash array map.
// Assumes the constants header is on the include path.
`include "flash_map_params.svh"
package flash_map_pkg;
    // One queued program byte: target space, address, data
    typedef struct packed {
        logic sec;
        logic [`ADDR_WIDTH-1:0] addr;
        logic [7:0] data;
    } wr_req_t;

    // Write/erase engine states
    typedef enum {ENG_IDLE, ENG_ERASE, ENG_FILL} eng_state_t;
endpackage : flash_map_pkg

/* File: hdl/serial_flash_array_map.sv */
// Serial flash array map: mode-0 serial slave, main array, security
// registers, read-only parameter space and a write FIFO.
// Assumes the serial clock is far slower than ref_clk_i (>= 8 cycles/half).
// Operation
// - Main array is 16 MiB, byte addressed by 24 bits.
// - 256 blocks of 64 KiB, each sixteen 4 KiB sectors, 4096 sectors.
// - 65536 pages of 256 bytes, each programmed on its own.
// - Programming only clears bits; setting bits back needs an erase.
// - Erase by sector, block or chip; never by single page.
// - Sector is aligned 4 KiB; sector number is address bits 23..12.
// - Four 256-byte security registers, register n at n times 1000h.
// - Set lock bit forbids program and erase of that register until reset.
// - Security registers 1..3 erase, program and lock independently.
// - Register 0 holds parameter data, also returned by parameter read.
// - Code 5Ah reads the parameter space, separate from main array.
// - Program or erase of the parameter space is refused.
// - Header at zero, reserved from 0010h, first table at 0030h.
// - Defined content ends at 006Fh; 0070h..00FFh reserved.
// - Parameter byte zero reads 53h.
// - Header byte 05h holds major revision 01h.
// - Header byte 06h holds 00h, one parameter header.
`timescale 1ns/1ps
`include "flash_map_params.svh"

// ==========================================================
// Write FIFO
module wr_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;

    // Extra pointer bit tells full from empty
    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready_o = !full;
    assign out_valid_o = (wr_ptr_r != rd_ptr_r);
    assign out_data_o = store_r[rd_ptr_r[AW-1:0]];

    // Pointers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (out_ready_i && out_valid_o) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // Storage
    always_ff @(posedge ref_clk_i) begin
        if (in_valid_i && !full) begin
            store_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end
endmodule : wr_fifo

// ==========================================================
// Top
module serial_flash_array_map #(
    parameter int ADDR_W = `ADDR_WIDTH,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic busy_o,
    output logic overrun_o
);
    localparam int PW = ADDR_W - 8;
    localparam int NPAGES = 2 ** PW;
    localparam int QW = $bits(flash_map_pkg::wr_req_t);

    // ==========================================================
    // Pin synchronisers and edge finding
    logic [1:0] sclk_sync_r;
    logic [1:0] cs_sync_r;
    logic [1:0] mosi_sync_r;
    logic sclk_d_r;
    logic cs_d_r;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic frame_end;

    // Two flops per pin; edges only from the second stage
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sclk_sync_r <= 2'h0;
            cs_sync_r <= 2'h3;
            mosi_sync_r <= 2'h0;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_sync_r <= {sclk_sync_r[0], sclk_i};
            cs_sync_r <= {cs_sync_r[0], cs_n_i};
            mosi_sync_r <= {mosi_sync_r[0], mosi_i};
            sclk_d_r <= sclk_sync_r[1];
            cs_d_r <= cs_sync_r[1];
        end
    end

    assign sclk_rise = sclk_sync_r[1] && !sclk_d_r;
    assign sclk_fall = !sclk_sync_r[1] && sclk_d_r;
    assign selected = !cs_sync_r[1];
    assign frame_end = cs_sync_r[1] && !cs_d_r;

    // ==========================================================
    // Storage and state declarations
    logic [7:0] mem_r [NPAGES*256];
    logic [7:0] sec_mem_r [1024];
    logic [NPAGES-1:0] page_erased_r;
    logic [3:0] sec_erased_r;
    logic [3:1] lock_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic [2:0] byte_idx_r;
    logic [7:0] cmd_r;
    logic [7:0] last_byte_r;
    logic [23:0] addr_r;
    logic [6:0] tx_r;
    logic [7:0] rd_byte_r;
    logic wel_r;
    logic prog_ok_r;
    flash_map_pkg::eng_state_t state_r;
    logic [PW-1:0] er_page_r;
    logic [PW:0] er_left_r;
    logic [7:0] fill_cnt_r;

    logic [7:0] rx_byte;
    logic byte_done;
    logic [23:0] addr_nxt;
    logic [1:0] sec_n;
    logic sec_addr_ok;
    logic sec_writable;
    logic is_read;
    logic [2:0] data_idx;
    logic read_phase;
    logic busy_now;
    logic erase_go;
    logic sec_erase_go;
    logic prog_push;
    logic fifo_ready;
    logic fifo_valid;
    logic pop;
    logic head_erased;
    logic [QW-1:0] head_bits;
    flash_map_pkg::wr_req_t head;
    flash_map_pkg::wr_req_t push_req;

    // Parameter space: register 0 content, FFh where nothing is defined
    function automatic logic [7:0] param_byte(input logic [7:0] a);
        case (a)
            8'h00: param_byte = `PT_SIG_S;
            8'h01: param_byte = `PT_SIG_F;
            8'h02: param_byte = `PT_SIG_D;
            8'h03: param_byte = `PT_SIG_P;
            8'h04: param_byte = `PT_MINOR_REV;
            8'h05: param_byte = `PT_MAJOR_REV;
            8'h06: param_byte = `PT_NUM_HEADERS;
            // Table body from 30h..6Fh not loaded; reserved 10h, 70h up
            default: param_byte = `ERASED_BYTE;
        endcase
    endfunction : param_byte

    // ==========================================================
    // Frame decode
    assign rx_byte = {shift_r, mosi_sync_r[1]};
    assign byte_done = selected && sclk_rise && (bit_cnt_r == 3'd7);
    assign addr_nxt = {addr_r[15:0], rx_byte};
    assign sec_n = addr_r[13:12];
    assign sec_addr_ok = (addr_r[23:14] == 10'h000) &&
                         (addr_r[11:8] == 4'h0);
    // Register 0 never writable; others only while unlocked
    assign sec_writable = sec_addr_ok && (sec_n != 2'd0) &&
                          !lock_r[sec_n];
    assign is_read = (cmd_r == `CMD_READ) || (cmd_r == `CMD_SEC_READ) ||
                     (cmd_r == `CMD_PARAM_READ) ||
                     (cmd_r == `CMD_STAT1) || (cmd_r == `CMD_STAT2);
    assign data_idx = (cmd_r == `CMD_PARAM_READ) ? `IDX_PARAM_DATA :
                      ((cmd_r == `CMD_STAT1) || (cmd_r == `CMD_STAT2)) ?
                      `IDX_STAT_DATA : `IDX_READ_DATA;
    assign read_phase = selected && is_read && (byte_idx_r >= data_idx);
    assign busy_now = (state_r != flash_map_pkg::ENG_IDLE) || fifo_valid;
    assign erase_go = frame_end && wel_r && !busy_now &&
        ((((cmd_r == `CMD_SECT_ERASE) || (cmd_r == `CMD_BLK_ERASE)) &&
          (byte_idx_r == `IDX_READ_DATA)) ||
         ((cmd_r == `CMD_CHIP_ERASE) &&
          (byte_idx_r == `IDX_STAT_DATA)));
    assign sec_erase_go = frame_end && wel_r && !busy_now &&
        (cmd_r == `CMD_SEC_ERASE) && (byte_idx_r == `IDX_READ_DATA) &&
        sec_writable;
    assign prog_push = byte_done && prog_ok_r &&
                       (byte_idx_r >= `IDX_READ_DATA);

    // ==========================================================
    // Serial receiver: bit and byte counting, command and address
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !selected) begin
            bit_cnt_r <= 3'd0;
            byte_idx_r <= 3'd0;
        end else if (sclk_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (byte_done && (byte_idx_r != `IDX_BYTE_SAT)) begin
                byte_idx_r <= byte_idx_r + 3'd1;
            end
        end
    end

    // Shift register, command and last byte
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            shift_r <= 7'h00;
            cmd_r <= 8'h00;
            last_byte_r <= 8'h00;
        end else if (selected && sclk_rise) begin
            shift_r <= rx_byte[6:0];
            if (byte_done) begin
                last_byte_r <= rx_byte;
                if (byte_idx_r == 3'd0) begin
                    cmd_r <= rx_byte;
                end
            end
        end
    end

    // Address: three bytes, then page wrap on program, linear on read
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            addr_r <= 24'h000000;
        end else if (byte_done && (byte_idx_r != 3'd0) &&
                     (byte_idx_r <= `IDX_ADDR_DONE)) begin
            addr_r <= addr_nxt;
        end else if (prog_push) begin
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
        end else if (read_phase && sclk_fall && (bit_cnt_r == 3'd0)) begin
            addr_r <= addr_r + 24'h000001;
        end
    end

    // ==========================================================
    // Read source, one cycle behind the address
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rd_byte_r <= `ERASED_BYTE;
        end else begin
            case (cmd_r)
                `CMD_READ: begin
                    rd_byte_r <= page_erased_r[addr_r[ADDR_W-1:8]] ?
                        `ERASED_BYTE : mem_r[addr_r[ADDR_W-1:0]];
                end
                `CMD_SEC_READ: begin
                    if (!sec_addr_ok) begin
                        rd_byte_r <= `ERASED_BYTE;
                    end else if (sec_n == 2'd0) begin
                        rd_byte_r <= param_byte(addr_r[7:0]);
                    end else begin
                        rd_byte_r <= sec_erased_r[sec_n] ? `ERASED_BYTE :
                            sec_mem_r[{sec_n, addr_r[7:0]}];
                    end
                end
                `CMD_PARAM_READ: begin
                    // Own space: only 256 bytes, higher addresses no alias
                    rd_byte_r <= (addr_r[23:8] == 16'h0000) ?
                        param_byte(addr_r[7:0]) : `ERASED_BYTE;
                end
                `CMD_STAT1: begin
                    rd_byte_r <= {overrun_o, 5'h00, wel_r, busy_now};
                end
                `CMD_STAT2: begin
                    rd_byte_r <= {2'h0, lock_r, 3'h0};
                end
                default: begin
                    rd_byte_r <= `ERASED_BYTE;
                end
            endcase
        end
    end

    // Serial transmitter: mode 0, new bit on each falling edge
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_r <= 7'h00;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            miso_oe_o <= selected;
            if (!selected) begin
                miso_o <= 1'b0;
            end else if (read_phase && sclk_fall) begin
                if (bit_cnt_r == 3'd0) begin
                    miso_o <= rd_byte_r[7];
                    tx_r <= rd_byte_r[6:0];
                end else begin
                    miso_o <= tx_r[6];
                    tx_r <= {tx_r[5:0], 1'b0};
                end
            end
        end
    end

    // ==========================================================
    // Write enable, program permission, locks, overrun, busy
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wel_r <= 1'b0;
        end else if (frame_end) begin
            if ((cmd_r == `CMD_WREN) && (byte_idx_r == `IDX_STAT_DATA)) begin
                wel_r <= 1'b1;
            end else if ((cmd_r == `CMD_WRDI) || (cmd_r == `CMD_PROG) ||
                         (cmd_r == `CMD_SEC_PROG) || erase_go ||
                         sec_erase_go || (cmd_r == `CMD_WSTAT2)) begin
                wel_r <= 1'b0;
            end
        end
    end

    // Permission decided once the address is complete
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !selected) begin
            prog_ok_r <= 1'b0;
        end else if (byte_done && (byte_idx_r == `IDX_ADDR_DONE)) begin
            prog_ok_r <= wel_r && !busy_now &&
                ((cmd_r == `CMD_PROG) ||
                 ((cmd_r == `CMD_SEC_PROG) &&
                  (addr_nxt[23:14] == 10'h000) &&
                  (addr_nxt[11:8] == 4'h0) &&
                  (addr_nxt[13:12] != 2'd0) &&
                  !lock_r[addr_nxt[13:12]]));
        end
    end

    // One-time lock bits: set only, never cleared by any command
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            lock_r <= 3'h0;
        end else if (frame_end && wel_r && (cmd_r == `CMD_WSTAT2) &&
                     (byte_idx_r == `IDX_WSTAT2_END)) begin
            lock_r <= lock_r | last_byte_r[5:3];
        end
    end

    // Sticky overrun; a drop beats the clear of a new program
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            overrun_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            busy_o <= busy_now;
            if (prog_push && !fifo_ready) begin
                overrun_o <= 1'b1;
            end else if (byte_done && (byte_idx_r == `IDX_ADDR_DONE) &&
                         ((cmd_r == `CMD_PROG) ||
                          (cmd_r == `CMD_SEC_PROG))) begin
                overrun_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Program byte queue
    assign push_req = '{sec: (cmd_r == `CMD_SEC_PROG), addr: addr_r,
                        data: rx_byte};
    assign head = flash_map_pkg::wr_req_t'(head_bits);
    assign head_erased = head.sec ? sec_erased_r[head.addr[13:12]] :
                         page_erased_r[head.addr[ADDR_W-1:8]];
    // Erased page is first filled with ones, then written
    assign pop = (state_r == flash_map_pkg::ENG_IDLE) && fifo_valid &&
                 !head_erased;

    wr_fifo #(
        .WIDTH(QW),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .in_valid_i(prog_push),
        .in_ready_o(fifo_ready),
        .in_data_i(push_req),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(head_bits)
    );

    // ==========================================================
    // Engine: page-walking erase and page fill
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r <= flash_map_pkg::ENG_IDLE;
            er_page_r <= '0;
            er_left_r <= '0;
            fill_cnt_r <= 8'h00;
        end else begin
            case (state_r)
                flash_map_pkg::ENG_IDLE: begin
                    fill_cnt_r <= 8'h00;
                    if (erase_go) begin
                        state_r <= flash_map_pkg::ENG_ERASE;
                        if (cmd_r == `CMD_SECT_ERASE) begin
                            er_page_r <= {addr_r[ADDR_W-1:12], 4'h0};
                            er_left_r <= (PW+1)'(`SECTOR_PAGES);
                        end else if (cmd_r == `CMD_BLK_ERASE) begin
                            er_page_r <= addr_r[ADDR_W-1:8] & ~PW'(8'hff);
                            er_left_r <= (PW+1)'(`BLOCK_PAGES);
                        end else begin
                            er_page_r <= '0;
                            er_left_r <= (PW+1)'(NPAGES);
                        end
                    end else if (fifo_valid && head_erased) begin
                        state_r <= flash_map_pkg::ENG_FILL;
                    end
                end
                flash_map_pkg::ENG_ERASE: begin
                    er_page_r <= er_page_r + 1'b1;
                    er_left_r <= er_left_r - 1'b1;
                    if (er_left_r == (PW+1)'(1)) begin
                        state_r <= flash_map_pkg::ENG_IDLE;
                    end
                end
                flash_map_pkg::ENG_FILL: begin
                    fill_cnt_r <= fill_cnt_r + 8'h01;
                    if (fill_cnt_r == `LAST_BYTE_IN_PAGE) begin
                        state_r <= flash_map_pkg::ENG_IDLE;
                    end
                end
                default: begin
                    state_r <= flash_map_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Erased markers; array starts blank, retention is not modelled
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            page_erased_r <= '1;
            sec_erased_r <= 4'hf;
        end else begin
            if (state_r == flash_map_pkg::ENG_ERASE) begin
                page_erased_r[er_page_r] <= 1'b1;
            end
            if ((state_r == flash_map_pkg::ENG_FILL) &&
                (fill_cnt_r == `LAST_BYTE_IN_PAGE)) begin
                if (head.sec) begin
                    sec_erased_r[head.addr[13:12]] <= 1'b0;
                end else begin
                    page_erased_r[head.addr[ADDR_W-1:8]] <= 1'b0;
                end
            end
            if (sec_erase_go) begin
                sec_erased_r[sec_n] <= 1'b1;
            end
        end
    end

    // Main array writes: fill with ones, then AND only clears bits
    always_ff @(posedge ref_clk_i) begin
        if ((state_r == flash_map_pkg::ENG_FILL) && !head.sec) begin
            mem_r[{head.addr[ADDR_W-1:8], fill_cnt_r}] <= `ERASED_BYTE;
        end else if (pop && !head.sec) begin
            mem_r[head.addr[ADDR_W-1:0]] <=
                mem_r[head.addr[ADDR_W-1:0]] & head.data;
        end
    end

    // Security register writes, same one-way rule
    always_ff @(posedge ref_clk_i) begin
        if ((state_r == flash_map_pkg::ENG_FILL) && head.sec) begin
            sec_mem_r[{head.addr[13:12], fill_cnt_r}] <= `ERASED_BYTE;
        end else if (pop && head.sec) begin
            sec_mem_r[{head.addr[13:12], head.addr[7:0]}] <=
                sec_mem_r[{head.addr[13:12], head.addr[7:0]}] &
                head.data;
        end
    end
endmodule : serial_flash_array_map

/* File: bench/flash_map_monitor.sv */
// Port checker: select, data-out and busy timing.
// Assumes a bind onto serial_flash_array_map; one clock domain.
`timescale 1ns/1ps
// ==========================================
// Checker
module flash_map_monitor (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic busy_o,
    input wire logic overrun_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Select edges pass two syncs and one output stage
    a_oe_on_select: assert property ($fell(cs_n_i) |=>
        !miso_oe_o ##[1:3] miso_oe_o) else $error("late enable");
    a_oe_off_deselect: assert property ($rose(cs_n_i) |=>
        miso_oe_o ##[1:3] !miso_oe_o) else $error("late disable");
    a_oe_held_selected: assert property (!cs_n_i [*4] |-> miso_oe_o)
        else $error("enable lost");
    a_out_low_idle: assert property (!miso_oe_o && !$past(miso_oe_o)
        |-> !miso_o) else $error("data-out not low");
    // Data-out moves only in the low half of the serial clock
    a_out_moves_low: assert property ($changed(miso_o) |-> !sclk_i)
        else $error("data-out moved with clock high");
    a_flags_reset: assert property ($fell(reset_i) |->
        !busy_o && !overrun_o && !miso_oe_o) else $error("flags after reset");
    a_overrun_sticky: assert property (overrun_o && !miso_oe_o
        |=> overrun_o) else $error("overrun cleared");
    // Shrunk array: erase and fill end within 1000
    a_busy_bounded: assert property ($rose(busy_o) |->
        ##[1:1000] !busy_o) else $error("busy too long");
    c_busy: cover property ($rose(busy_o));
    c_frame_end: cover property ($fell(miso_oe_o));
    c_data_one: cover property ($rose(miso_o));
endmodule : flash_map_monitor

bind serial_flash_array_map flash_map_monitor flash_map_monitor_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .busy_o(busy_o), .overrun_o(overrun_o));

/* File: bench/spi_host_model.sv */
// Serial host model: mode 0 frames, MSB first, byte queues.
// Assumes the bench loads txq, calls frame, then reads rxq.
`timescale 1ns/1ps
// ==========================================
// Host model
module spi_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    // Idle: clock low and still, deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Frame of n bytes, 160 ns a bit, sampled on the rise
    task automatic frame(input int n);
        logic [7:0] b;
        logic [7:0] r;
        rxq = {};
        @(negedge clk_i);
        cs_n_o = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            b = txq[i];
            for (int k = 7; k >= 0; k--) begin
                mosi_o = b[k];
                #80 sclk_o = 1'b1;
                r = {r[6:0], miso_i};
                #80 sclk_o = 1'b0;
            end
            rxq.push_back(r);
        end
        #80 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line must not look held
        #320;
    endtask : frame
endmodule : spi_host_model

/* File: bench/tb_serial_flash_array_map.sv */
// Bench: parameter reads, array program and erase, security locks.
// Assumes the host model on the serial pins; array of 64 KiB.
`timescale 1ns/1ps
// ==========================================
// Bench top
module tb_serial_flash_array_map;
    logic ref_clk_i, reset_i, sclk, cs_n, mosi, miso, oe, busy, ovr;
    int bad_count = 0;
    int checks = 0;
    logic [23:0] a;
    logic [7:0] d, e;
    logic [7:0] hdr [7] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00};
    serial_flash_array_map #(.ADDR_W(16), .FIFO_DEPTH(8))
    serial_flash_array_map_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
        .miso_oe_o(oe), .busy_o(busy), .overrun_o(ovr));
    spi_host_model spi_host_model_i (.clk_i(ref_clk_i), .miso_i(miso),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    // 250 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Parameter byte: header, then fixed fill
    function automatic logic [7:0] pexp(input logic [7:0] x);
        return (x < 7) ? hdr[x] : 8'hff;
    endfunction : pexp
    function automatic logic [7:0] rx(input int k);
        return spi_host_model_i.rxq[k];
    endfunction : rx
    task automatic chk(input string w, input logic [7:0] x, g);
        checks++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", w, x, g);
        end
    endtask : chk
    // One frame, then a bounded wait for idle
    task automatic op(input logic [7:0] c, input logic [23:0] ad,
        input logic [7:0] dv, input int n);
        spi_host_model_i.txq = {c, ad[23:16], ad[15:8], ad[7:0]};
        for (int i = 4; i < n; i++) spi_host_model_i.txq.push_back(dv);
        spi_host_model_i.frame(n);
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge ref_clk_i);
        chk("idle", 8'h00, {6'h00, ovr, busy});
    endtask : op
    // Write-enable frame first
    task automatic we(input logic [7:0] c, input logic [23:0] ad,
        input logic [7:0] dv, input int n);
        op(8'h06, 24'h0, 8'h0, 1);
        op(c, ad, dv, n);
    endtask : we
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // Watchdog: tests need ~220 us
    initial begin
        #390_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        reset_i = 1'b1;
        void'($urandom(32'h7ed270b0));
        repeat (6) @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        // Refused program; header, edges, random start
        we(8'h42, 24'h0, 8'h00, 5);
        for (int j = 0; j < 3; j++) begin
            a = (j == 0) ? 24'h0 : (j == 1) ? 24'h6c : 24'($urandom_range(240));
            op(8'h5a, a, 8'h00, 12);
            for (int i = 0; i < 7; i++) chk("param", pexp(a + i), rx(5 + i));
        end
        op(8'h48, 24'h0, 8'h00, 8);
        for (int i = 0; i < 4; i++) chk("sec0", pexp(i), rx(4 + i));
        $display("test param done");
        // Main array: blank, AND on reprogram, sector and chip erase
        a = 24'($urandom_range(24'h00efff));
        d = 8'($urandom);
        e = 8'($urandom);
        op(8'h03, a, 8'hff, 5);
        chk("blank", 8'hff, rx(4));
        we(8'h02, a, d, 5);
        we(8'h02, a + 24'h1000, d, 5);
        we(8'h02, a, e, 5);
        op(8'h03, a, 8'hff, 5);
        chk("reprog", d & e, rx(4));
        we(8'h20, {a[23:12], 12'($urandom)}, 8'h00, 4);
        op(8'h03, a, 8'hff, 5);
        chk("erased", 8'hff, rx(4));
        op(8'h03, a + 24'h1000, 8'hff, 5);
        chk("kept", d, rx(4));
        we(8'hd8, a, 8'h00, 4);
        op(8'h03, a + 24'h1000, 8'hff, 5);
        chk("block", 8'hff, rx(4));
        we(8'h02, a + 24'h1000, d, 5);
        we(8'hc7, 24'h0, 8'h00, 1);
        op(8'h03, a + 24'h1000, 8'hff, 5);
        chk("chip", 8'hff, rx(4));
        $display("test array done");
        // Register 1 locked keeps data; register 2 still erases
        we(8'h42, {16'h0010, d}, e, 5);
        op(8'h48, {16'h0010, d}, 8'hff, 5);
        chk("sec1", e, rx(4));
        we(8'h31, 24'h080000, 8'h00, 2);
        we(8'h44, 24'h001000, 8'h00, 4);
        op(8'h48, {16'h0010, d}, 8'hff, 5);
        chk("locked", e, rx(4));
        we(8'h42, 24'h002000, d, 5);
        we(8'h44, 24'h002000, 8'h00, 4);
        op(8'h48, 24'h002000, 8'hff, 5);
        chk("sec2", 8'hff, rx(4));
        $display("test security done");
        report_and_stop();
    end
endmodule : tb_serial_flash_array_map
